// [logic/afd_add_flags.sv]
`timescale 1ns/1ps
`default_nettype none
module afd_add_flags
	import afd_pkg::*;
#(
	parameter int DW = afd_pkg::AFD_DW
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	// Request from decoder
	input wire logic req_i,
	input wire afd_pkg::afd_op_s op_i,
	input wire logic [DW-1:0] dst_val_i,
	input wire logic [DW-1:0] reg_src_i,
	input wire logic [DW-1:0] dir_src_i,
	input wire logic [DW-1:0] ind_src_i,
	input wire logic [DW-1:0] imm_src_i,
	// Write back to register file
	output logic wb_en_o,
	output afd_pkg::afd_dst_e wb_dst_o,
	output logic [afd_pkg::AFD_RW-1:0] wb_idx_o,
	output logic [DW-1:0] wb_data_o,
	// Flags
	output afd_pkg::afd_flags_s flags_o
);
	import afd_pkg::*;

	logic [DW-1:0] src;
	logic [DW-1:0] a_m;
	logic [DW-1:0] b_m;
	logic [DW-1:0] sum;
	logic [DW-1:0] cout;
	logic [DW-1:0] res;
	logic msb;
	logic c7;
	logic c6;
	logic wb_en_q;
	afd_dst_e wb_dst_q;
	logic [AFD_RW-1:0] wb_idx_q;
	logic [DW-1:0] wb_data_q;
	afd_flags_s flags_q;
	afd_flags_s flags_d;

	always_comb begin
		unique case (op_i.mode)
			AFD_SRC_REG: src = reg_src_i;
			AFD_SRC_DIR: src = dir_src_i;
			AFD_SRC_IND: src = ind_src_i;
			AFD_SRC_IMM: src = imm_src_i;
		endcase
	end

	// Upper bits masked so a narrow add cannot leak carries into its result
	always_comb begin
		a_m = AFD_ZERO;
		b_m = AFD_ZERO;
		unique case (op_i.width)
			AFD_W8: begin
				a_m[AFD_W8_BITS-1:0] = dst_val_i[AFD_W8_BITS-1:0];
				b_m[AFD_W8_BITS-1:0] = src[AFD_W8_BITS-1:0];
			end
			AFD_W16: begin
				a_m[AFD_W16_BITS-1:0] = dst_val_i[AFD_W16_BITS-1:0];
				b_m[AFD_W16_BITS-1:0] = src[AFD_W16_BITS-1:0];
			end
			default: begin
				a_m = dst_val_i;
				b_m = src;
			end
		endcase
	end

	afd_adder #(.DW(DW)) u_add (
		.a_i(a_m),
		.b_i(b_m),
		.sum_o(sum),
		.cout_o(cout)
	);

	// carry taps in top byte
	// Result clipped too: the carry out lands above a narrow width
	always_comb begin
		res = AFD_ZERO;
		unique case (op_i.width)
			AFD_W8: begin
				res[AFD_W8_BITS-1:0] = sum[AFD_W8_BITS-1:0];
				c7 = cout[AFD_W8_BITS-1];
				c6 = cout[AFD_W8_BITS-2];
				msb = sum[AFD_W8_BITS-1];
			end
			AFD_W16: begin
				res[AFD_W16_BITS-1:0] = sum[AFD_W16_BITS-1:0];
				c7 = cout[AFD_W16_BITS-1];
				c6 = cout[AFD_W16_BITS-2];
				msb = sum[AFD_W16_BITS-1];
			end
			default: begin
				res = sum;
				c7 = cout[DW-1];
				c6 = cout[DW-2];
				msb = sum[DW-1];
			end
		endcase
	end

	always_comb begin
		flags_d = flags_q;
		flags_d.carry_flag = c7;
		flags_d.signed_range_flag = c7 ^ c6;
		if (op_i.width == AFD_W8) begin
			flags_d.aux_carry_flag = cout[AFD_AUX_BIT];
		end
		flags_d.neg_flag = msb;
		flags_d.zero_flag = (res == AFD_ZERO);
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			flags_q <= AFD_FLAGS_RST;
		end else if (clk_en_i && req_i) begin
			flags_q <= flags_d;
		end
	end

	always_ff @(posedge mclk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wb_en_q <= 1'b0;
			wb_dst_q <= AFD_DST_REG;
			wb_idx_q <= '0;
			wb_data_q <= AFD_ZERO;
		end else if (clk_en_i) begin
			wb_en_q <= req_i;
			if (req_i) begin
				wb_dst_q <= op_i.dst;
				wb_idx_q <= op_i.dst_idx;
				wb_data_q <= res;
			end
		end
	end

	assign wb_en_o = wb_en_q;
	assign wb_dst_o = wb_dst_q;
	assign wb_idx_o = wb_idx_q;
	assign wb_data_o = wb_data_q;
	assign flags_o = flags_q;

	AST_CARRY: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		clk_en_i && req_i && op_i.width == AFD_W8
		|=> flags_o.carry_flag == (({1'b0, $past(dst_val_i[7:0])}
			+ {1'b0, $past(src[7:0])}) >> 8))
		else $error("carry flag wrong on byte add");

	AST_AUX: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		clk_en_i && req_i && op_i.width == AFD_W8
		|=> flags_o.aux_carry_flag == (({1'b0, $past(dst_val_i[3:0])}
			+ {1'b0, $past(src[3:0])}) >> 4))
		else $error("aux carry flag wrong");

	AST_SRANGE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		clk_en_i && req_i && op_i.width == AFD_W8
		&& dst_val_i[7] == src[7] && sum[7] != src[7]
		|=> flags_o.signed_range_flag)
		else $error("signed range flag missed");

	AST_WB: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		clk_en_i && req_i && op_i.width == AFD_W32
		|=> wb_en_o && wb_data_o == $past(dst_val_i) + $past(src)
			&& wb_dst_o == $past(op_i.dst))
		else $error("write back mismatch");

	AST_ZERO: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		wb_en_o |-> flags_o.zero_flag == (wb_data_o == AFD_ZERO))
		else $error("zero flag wrong");

	AST_W16: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		clk_en_i && req_i && op_i.width == AFD_W16
		|=> flags_o.carry_flag == (({1'b0, $past(dst_val_i[15:0])}
			+ {1'b0, $past(src[15:0])}) >> 16))
		else $error("16-bit carry wrong");

	AST_IMM: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		clk_en_i && req_i && op_i.mode == AFD_SRC_IMM && op_i.width == AFD_W32
		|=> wb_data_o == $past(dst_val_i) + $past(imm_src_i))
		else $error("immediate source not used");

	AST_NEG: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		wb_en_o && $past(clk_en_i) && $past(req_i) && $past(op_i.width) == AFD_W8
		|-> flags_o.neg_flag == wb_data_o[7])
		else $error("negative flag wrong");

	AST_AUX_HOLD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		clk_en_i && req_i && op_i.width != AFD_W8
		|=> $stable(flags_o.aux_carry_flag))
		else $error("aux carry flag changed on wide add");

	AST_FREEZE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
		!clk_en_i |=> $stable(flags_o) && $stable(wb_en_o) && $stable(wb_data_o))
		else $error("state moved while clock enable low");
endmodule : afd_add_flags
`default_nettype wire

// [logic/afd_pkg.sv]
// Contract
// - Add source to destination; write sum back to that same destination.
// - Carry flag equals carry out of bit 7 of the top byte.
// - On byte adds, aux carry flag equals carry out of bit 3.
// - Signed range flag set when carries out of bits 6 and 7 differ.
// - Carry and overflow bits sit in the most significant byte, any width.
package afd_pkg;
	localparam int AFD_DW = 32;
	localparam int AFD_RW = 4;
	localparam logic [AFD_DW-1:0] AFD_ZERO = 32'h0000_0000;
	localparam int AFD_AUX_BIT = 3;
	localparam int AFD_W8_BITS = 8;
	localparam int AFD_W16_BITS = 16;
	localparam logic [4:0] AFD_FLAGS_RST = 5'h00;

	typedef enum logic [1:0] {
		AFD_W8,
		AFD_W16,
		AFD_W32
	} afd_width_e;

	typedef enum logic [1:0] {
		AFD_SRC_REG,
		AFD_SRC_DIR,
		AFD_SRC_IND,
		AFD_SRC_IMM
	} afd_mode_e;

	typedef enum logic {
		AFD_DST_REG,
		AFD_DST_ACC
	} afd_dst_e;

	typedef struct packed {
		logic carry_flag;
		logic aux_carry_flag;
		logic signed_range_flag;
		logic neg_flag;
		logic zero_flag;
	} afd_flags_s;

	typedef struct packed {
		afd_width_e width;
		afd_mode_e mode;
		afd_dst_e dst;
		logic [AFD_RW-1:0] dst_idx;
	} afd_op_s;
endpackage : afd_pkg

// [logic/afd_adder.sv]
`timescale 1ns/1ps
`default_nettype none
module afd_adder #(
	parameter int DW = 32
) (
	// Operands
	input wire logic [DW-1:0] a_i,
	input wire logic [DW-1:0] b_i,
	// Result with per-bit carry outs
	output logic [DW-1:0] sum_o,
	output logic [DW-1:0] cout_o
);
	logic [DW:0] c;
	assign c[0] = 1'b0;
	genvar g;
	generate
		for (g = 0; g < DW; g++) begin : g_bit
			assign sum_o[g] = a_i[g] ^ b_i[g] ^ c[g];
			assign c[g+1] = (a_i[g] & b_i[g]) | (c[g] & (a_i[g] ^ b_i[g]));
		end
	endgenerate
	assign cout_o = c[DW:1];
endmodule : afd_adder
`default_nettype wire

// [testbench/afd_regfile.sv]
`timescale 1ns/1ps
`default_nettype none
module afd_regfile
	import afd_pkg::*;
(
	// Clock
	input wire logic mclk_i,
	// Preload from bench
	input wire logic ld_en_i,
	input wire logic [31:0] ld_val_i,
	// Write back
	input wire logic wb_en_i,
	input wire afd_pkg::afd_dst_e wb_dst_i,
	input wire logic [3:0] wb_idx_i,
	input wire logic [31:0] wb_data_i,
	// Operand read
	input wire afd_pkg::afd_op_s op_i,
	output logic [31:0] dst_val_o
);
	import afd_pkg::*;
	logic [31:0] regs_q [16];
	logic [31:0] acc_q;
	assign dst_val_o = (op_i.dst == AFD_DST_ACC) ? acc_q : regs_q[op_i.dst_idx];
	always_ff @(posedge mclk_i) begin
		if (wb_en_i && wb_dst_i == AFD_DST_ACC) acc_q <= wb_data_i;
		else if (wb_en_i) regs_q[wb_idx_i] <= wb_data_i;
		else if (ld_en_i && op_i.dst == AFD_DST_ACC) acc_q <= ld_val_i;
		else if (ld_en_i) regs_q[op_i.dst_idx] <= ld_val_i;
	end
endmodule : afd_regfile
`default_nettype wire

// [testbench/add_flags_datapath_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module add_flags_datapath_bench;
	import afd_pkg::*;
	logic mclk_i = 1'b0, sys_rst_i = 1'b1, clk_en_i = 1'b1, req_i = 1'b0, ld_en = 1'b0;
	afd_op_s op_i = '0;
	logic [31:0] dst_val, ld_val = '0, reg_src_i = '0, dir_src_i = '0, ind_src_i = '0;
	logic [31:0] imm_src_i = '0, wb_data_o;
	logic wb_en_o, aux_q = 1'b0;
	logic [36:0] last_e = '0;
	afd_dst_e wb_dst_o;
	logic [3:0] wb_idx_o;
	afd_flags_s flags_o;
	int n_mismatch = 0, comparisons = 0;
	afd_add_flags uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i),
		.req_i(req_i), .op_i(op_i), .dst_val_i(dst_val), .reg_src_i(reg_src_i),
		.dir_src_i(dir_src_i), .ind_src_i(ind_src_i), .imm_src_i(imm_src_i),
		.wb_en_o(wb_en_o), .wb_dst_o(wb_dst_o), .wb_idx_o(wb_idx_o),
		.wb_data_o(wb_data_o), .flags_o(flags_o));
	afd_regfile rf (.mclk_i(mclk_i), .ld_en_i(ld_en), .ld_val_i(ld_val), .wb_en_i(wb_en_o),
		.wb_dst_i(wb_dst_o), .wb_idx_i(wb_idx_o), .wb_data_i(wb_data_o), .op_i(op_i),
		.dst_val_o(dst_val));
	initial begin
		forever #50 mclk_i = ~mclk_i;
	end
	task automatic chk(string nm, logic [36:0] seen, logic [36:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic summarize();
		if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : summarize
	// Sum and flags; aux held on wide adds
	function automatic logic [36:0] calc(int n, logic [31:0] a, logic [31:0] b, logic aux);
		logic [32:0] m, s, s6;
		logic [4:0] c3;
		m = (33'h1 << n) - 33'h1;
		s = (a & m) + (b & m);
		s6 = (a & (m >> 1)) + (b & (m >> 1));
		c3 = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		if (n == 8) aux = c3[4];
		return {s[31:0] & m[31:0], s[n], aux, s[n] ^ s6[n-1], s[n-1], (s & m) == 33'h0};
	endfunction : calc
	task automatic do_add(afd_width_e w, afd_mode_e md, afd_dst_e d, logic [3:0] ix,
		logic [31:0] dv, logic [31:0] sv, input int hold = 0);
		logic [36:0] e;
		e = calc(w == AFD_W8 ? 8 : w == AFD_W16 ? 16 : 32, dv, sv, aux_q);
		aux_q = e[3];
		@(posedge mclk_i);
		op_i <= '{w, md, d, ix};
		ld_en <= 1'b1;
		ld_val <= dv;
		@(posedge mclk_i);
		ld_en <= 1'b0;
		req_i <= 1'b1;
		reg_src_i <= md == AFD_SRC_REG ? sv : ~sv;
		dir_src_i <= md == AFD_SRC_DIR ? sv : ~sv;
		ind_src_i <= md == AFD_SRC_IND ? sv : ~sv;
		imm_src_i <= md == AFD_SRC_IMM ? sv : ~sv;
		if (hold > 0) clk_en_i <= 1'b0;
		repeat (hold) @(posedge mclk_i);
		if (hold > 0) begin
			@(negedge mclk_i);
			chk("frozen wb_en", wb_en_o, 0);
			chk("frozen flags", flags_o, last_e[4:0]);
			@(posedge mclk_i);
			clk_en_i <= 1'b1;
		end
		@(posedge mclk_i);
		req_i <= 1'b0;
		@(negedge mclk_i);
		chk("wb_en", wb_en_o, 1);
		chk("sum", wb_data_o, e[36:5]);
		chk("flags", flags_o, e[4:0]);
		@(negedge mclk_i);
		chk("wb_en low", wb_en_o, 0);
		chk("dest", dst_val, e[36:5]);
		last_e = e;
	endtask : do_add
	// Request held while disabled must wait for the enable
	task automatic s_freeze();
		do_add(AFD_W8, AFD_SRC_DIR, AFD_DST_REG, 4'h2, 32'h0000_0080, 32'h0000_0080, 3);
	endtask : s_freeze
	task automatic s_reset();
		@(posedge mclk_i);
		sys_rst_i <= 1'b1;
		@(negedge mclk_i);
		chk("rst flags", flags_o, 0);
		chk("rst wb_en", wb_en_o, 0);
		chk("rst data", wb_data_o, 0);
		@(posedge mclk_i);
		sys_rst_i <= 1'b0;
		aux_q = 1'b0;
		last_e = '0;
	endtask : s_reset
	task automatic s_byte();
		do_add(AFD_W8, AFD_SRC_REG, AFD_DST_REG, 4'h1, 32'h0000_00C3, 32'h0000_00AA);
		for (int i = 0; i < 4; i++) begin
			do_add(AFD_W8, afd_mode_e'(i), AFD_DST_ACC, 4'h0, 32'h0000_000F, 32'h0000_0071);
		end
	endtask : s_byte
	// High junk must not leak into narrow sums
	task automatic s_wide();
		do_add(AFD_W16, AFD_SRC_IMM, AFD_DST_REG, 4'hF, 32'hABCD_7FFF, 32'h1234_0001);
		do_add(AFD_W32, AFD_SRC_DIR, AFD_DST_ACC, 4'h0, 32'hFFFF_FFFF, 32'h0000_0001);
		do_add(AFD_W32, AFD_SRC_IND, AFD_DST_REG, 4'h7, 32'h8000_0000, 32'h8000_0000);
		do_add(AFD_W16, AFD_SRC_REG, AFD_DST_REG, 4'h3, 32'h0000_C000, 32'h0000_4000);
	endtask : s_wide
	initial begin
		repeat (16) @(negedge mclk_i);
		chk("flags rst", flags_o, 0);
		chk("wb_en rst", wb_en_o, 0);
		@(posedge mclk_i);
		sys_rst_i <= 1'b0;
		s_byte();
		s_freeze();
		s_reset();
		s_wide();
		summarize();
	end
	initial begin
		repeat (2000) @(posedge mclk_i);
		n_mismatch++;
		summarize();
	end
endmodule : add_flags_datapath_bench
`default_nettype wire
